// *** hw/rstpwr_pkg.sv ***
// Package: constants and carriers for reset and low-power control
package rstpwr_pkg;
  localparam int MCLK_HZ = 100_000_000;
  localparam int OSC_PER_MACHINE = 12;
  localparam int RESET_MIN_OSC_PERIODS = 24;
  // Oscillator-period count; each osc period is one MCLK cycle here
  localparam int RESET_MIN_CYCLES = RESET_MIN_OSC_PERIODS;
  localparam int WAKE_STABLE_MS = 10;
  localparam int WAKE_STABLE_CYCLES = (MCLK_HZ / 1000) * WAKE_STABLE_MS;
  localparam int RCNT_W = 6;
  localparam int OSC_STARTUP_CYCLES = 64;

  // APB register map
  localparam logic [7:0] ADDR_PCTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQCFG = 8'h08;
  localparam int PCTRL_IDLE_BIT = 0;
  localparam int PCTRL_PD_BIT = 1;
  localparam int PCTRL_GF0_BIT = 2;
  localparam int PCTRL_GF1_BIT = 3;
  localparam logic [3:0] PCTRL_RST = 4'h0;
  localparam int IRQ_EN0_BIT = 0;
  localparam int IRQ_EN1_BIT = 1;
  localparam int IRQ_LVL0_BIT = 2;
  localparam int IRQ_LVL1_BIT = 3;
  localparam logic [3:0] IRQCFG_RST = 4'h0;
  localparam logic [7:0] PORT_RST = 8'hff;

  typedef enum logic [4:0] {
    ST_RESET = 5'h01,
    ST_RUN   = 5'h02,
    ST_IDLE  = 5'h04,
    ST_PDOWN = 5'h08,
    ST_EMUL  = 5'h10
  } pmode_e;

  typedef struct packed {
    logic [7:0] p0_o;
    logic p0_oe;
    logic [7:0] p1_o;
    logic [7:0] p2_o;
    logic [7:0] p3_o;
    logic weak_pull;
  } portdrv_s;
endpackage

// *** hw/pin_sync.sv ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_ff, s2_ff, s3_ff, q_ff;
  logic [W-1:0] nxt_q;
  always_comb begin
    nxt_q = q_ff;
    for (int i = 0; i < W; i++) begin
      if (s2_ff[i] == s3_ff[i]) begin
        nxt_q[i] = s3_ff[i];
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_ff <= INIT;
      s2_ff <= INIT;
      s3_ff <= INIT;
      q_ff <= INIT;
    end else if (ce) begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_ff <= nxt_q;
    end
  end
  assign dout = q_ff;
endmodule // pin_sync
`default_nettype wire

// *** hw/rstpwr_ctrl.sv ***
// Reset, idle, power-down and emulation-mode controller
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module rstpwr_ctrl
  import rstpwr_pkg::*;
#(
  parameter int WAKE_CYCLES = WAKE_STABLE_CYCLES,
  parameter int STARTUP_CYCLES = OSC_STARTUP_CYCLES
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic RST_PIN,
  input wire logic OSC_INPUT_PIN,
  output logic OSC_OUTPUT_PIN,
  output logic OSC_DIV2,
  output logic OSC_RUN,
  input wire logic EXT_IRQ_ZERO_N,
  input wire logic EXT_IRQ_ONE_N,
  input wire logic ALE_PIN_I,
  input wire logic PROGRAM_STORE_STROBE_I,
  output logic ALE_O,
  output logic ALE_OE,
  output logic PROGRAM_STORE_STROBE_O,
  output logic PROGRAM_STORE_STROBE_OE,
  output logic STROBE_WEAK_PULL,
  input wire logic EXT_PROG_MEM,
  input wire logic INSTR_DONE,
  input wire logic IRQ_PENDING,
  input wire logic [7:0] CPU_P0,
  input wire logic [7:0] CPU_P1,
  input wire logic [7:0] CPU_P2,
  input wire logic [7:0] CPU_P3,
  input wire logic [7:0] ADDR_HI,
  input wire logic CPU_ALE,
  input wire logic CPU_PSTROBE,
  output portdrv_s PORT_DRV,
  output logic CPU_HALT,
  output logic SPECIAL_FUNCTION_REGISTER_RESET,
  output logic WAKE_IRQ,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);
  localparam int WCNT_W = $clog2(WAKE_CYCLES + 1) + 1;

  function automatic logic irq_wake(input logic [3:0] cfg, input logic n0, input logic n1);
    irq_wake = (cfg[IRQ_EN0_BIT] & cfg[IRQ_LVL0_BIT] & ~n0) | (cfg[IRQ_EN1_BIT] & cfg[IRQ_LVL1_BIT] & ~n1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic rst_s, irq0_s, irq1_s, ale_s, pstrobe_s;
  pin_sync #(.W(5), .INIT(5'h1f)) u_sync (
    .clk(MCLK),
    .rst(RST),
    .ce(CE),
    .din({RST_PIN, EXT_IRQ_ZERO_N, EXT_IRQ_ONE_N, ALE_PIN_I, PROGRAM_STORE_STROBE_I}),
    .dout({rst_s, irq0_s, irq1_s, ale_s, pstrobe_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // State
  pmode_e st_ff, nxt_st;
  logic [RCNT_W-1:0] rcnt_ff, nxt_rcnt;
  logic [WCNT_W-1:0] wcnt_ff, nxt_wcnt;
  logic [3:0] pctrl_ff, nxt_pctrl;
  logic [3:0] irqcfg_ff, nxt_irqcfg;
  logic div_ff, nxt_div;
  logic osc_ff, nxt_osc;
  logic emul_arm_ff, nxt_emul_arm;
  logic wake_ff, nxt_wake;
  logic [31:0] prdata_ff, nxt_prdata;
  logic reset_hit;
  logic apb_wr, apb_rd, addr_ok;

  assign reset_hit = rst_s && (rcnt_ff >= RCNT_W'(RESET_MIN_CYCLES - 1));
  assign addr_ok = (PADDR == ADDR_PCTRL) || (PADDR == ADDR_STATUS) || (PADDR == ADDR_IRQCFG);
  assign apb_wr = PSEL && PENABLE && PWRITE && CE;
  // Read data caught at the setup edge so it stands through the access phase
  assign apb_rd = PSEL && !PENABLE && !PWRITE && CE;

  always_comb begin
    nxt_st = st_ff;
    nxt_rcnt = rst_s ? ((rcnt_ff == '1) ? rcnt_ff : rcnt_ff + 1'b1) : '0;
    nxt_wcnt = wcnt_ff;
    nxt_pctrl = pctrl_ff;
    nxt_irqcfg = irqcfg_ff;
    nxt_div = osc_ff ? ~div_ff : div_ff;
    nxt_osc = osc_ff;
    nxt_emul_arm = emul_arm_ff;
    nxt_wake = 1'b0;
    nxt_prdata = prdata_ff;
    if (apb_wr && PADDR == ADDR_PCTRL) begin
      nxt_pctrl = PWDATA[3:0];
    end
    if (apb_wr && PADDR == ADDR_IRQCFG) begin
      nxt_irqcfg = PWDATA[3:0];
    end
    if (apb_rd) begin
      case (PADDR)
        ADDR_PCTRL: nxt_prdata = {28'h0, pctrl_ff};
        ADDR_STATUS: nxt_prdata = {26'h0, osc_ff, st_ff};
        ADDR_IRQCFG: nxt_prdata = {28'h0, irqcfg_ff};
        default: nxt_prdata = 32'h0;
      endcase
    end
    case (st_ff)
      ST_RESET: begin
        nxt_osc = 1'b1;
        // Strap caught while in reset, sampled at release
        nxt_emul_arm = ~ale_s & pstrobe_s;
        if (!rst_s) begin
          nxt_st = (emul_arm_ff && !ale_s) ? ST_EMUL : ST_RUN;
        end
      end
      ST_RUN: begin
        if (INSTR_DONE && pctrl_ff[PCTRL_PD_BIT]) begin
          nxt_st = ST_PDOWN;
          nxt_osc = 1'b0;
        end else if (INSTR_DONE && pctrl_ff[PCTRL_IDLE_BIT]) begin
          nxt_st = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (IRQ_PENDING) begin
          nxt_st = ST_RUN;
          nxt_pctrl[PCTRL_IDLE_BIT] = 1'b0;
        end
      end
      ST_PDOWN: begin
        // Low level restarts the oscillator, high completes the exit
        if (irq_wake(irqcfg_ff, irq0_s, irq1_s)) begin
          nxt_osc = 1'b1;
          nxt_wcnt = (wcnt_ff == '1) ? wcnt_ff : wcnt_ff + 1'b1;
        end else if (osc_ff && wcnt_ff >= WCNT_W'(STARTUP_CYCLES)) begin
          nxt_st = ST_RUN;
          nxt_pctrl[PCTRL_PD_BIT] = 1'b0;
          nxt_wake = 1'b1;
          nxt_wcnt = '0;
        end else if (osc_ff) begin
          // Released too soon: oscillator not stable, stop again
          nxt_osc = 1'b0;
          nxt_wcnt = '0;
        end
      end
      ST_EMUL: begin
        nxt_st = ST_EMUL;
      end
      default: nxt_st = ST_RESET;
    endcase
    if (reset_hit) begin
      nxt_st = ST_RESET;
      nxt_pctrl = PCTRL_RST;
      nxt_irqcfg = IRQCFG_RST;
      nxt_osc = 1'b1;
      nxt_wcnt = '0;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      st_ff <= ST_RESET;
      rcnt_ff <= '0;
      wcnt_ff <= '0;
      pctrl_ff <= PCTRL_RST;
      irqcfg_ff <= IRQCFG_RST;
      div_ff <= 1'b0;
      osc_ff <= 1'b1;
      emul_arm_ff <= 1'b0;
      wake_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else if (CE) begin
      st_ff <= nxt_st;
      rcnt_ff <= nxt_rcnt;
      wcnt_ff <= nxt_wcnt;
      pctrl_ff <= nxt_pctrl;
      irqcfg_ff <= nxt_irqcfg;
      div_ff <= nxt_div;
      osc_ff <= nxt_osc;
      emul_arm_ff <= nxt_emul_arm;
      wake_ff <= nxt_wake;
      prdata_ff <= nxt_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign OSC_OUTPUT_PIN = osc_ff & ~OSC_INPUT_PIN;
  assign OSC_DIV2 = div_ff;
  assign OSC_RUN = osc_ff;
  assign CPU_HALT = (st_ff != ST_RUN);
  assign SPECIAL_FUNCTION_REGISTER_RESET = (st_ff == ST_RESET);
  assign WAKE_IRQ = wake_ff;
  assign PRDATA = prdata_ff;
  // No transfer completes while frozen; CE must not fall between setup and access
  assign PREADY = CE;
  assign PSLVERR = PSEL && PENABLE && !addr_ok;

  always_comb begin
    PORT_DRV.p0_o = CPU_P0;
    PORT_DRV.p0_oe = 1'b1;
    PORT_DRV.p1_o = CPU_P1;
    PORT_DRV.p2_o = CPU_P2;
    PORT_DRV.p3_o = CPU_P3;
    PORT_DRV.weak_pull = 1'b0;
    ALE_O = CPU_ALE;
    PROGRAM_STORE_STROBE_O = CPU_PSTROBE;
    ALE_OE = 1'b1;
    PROGRAM_STORE_STROBE_OE = 1'b1;
    STROBE_WEAK_PULL = 1'b0;
    case (st_ff)
      ST_IDLE: begin
        ALE_O = 1'b1;
        PROGRAM_STORE_STROBE_O = 1'b1;
        PORT_DRV.p0_oe = ~EXT_PROG_MEM;
        if (EXT_PROG_MEM) begin
          PORT_DRV.p2_o = ADDR_HI;
        end
      end
      ST_PDOWN: begin
        ALE_O = 1'b0;
        PROGRAM_STORE_STROBE_O = 1'b0;
        PORT_DRV.p0_oe = ~EXT_PROG_MEM;
      end
      ST_EMUL: begin
        PORT_DRV.p0_oe = 1'b0;
        PORT_DRV.weak_pull = 1'b1;
        PORT_DRV.p1_o = PORT_RST;
        PORT_DRV.p2_o = PORT_RST;
        PORT_DRV.p3_o = PORT_RST;
        ALE_OE = 1'b0;
        PROGRAM_STORE_STROBE_OE = 1'b0;
        STROBE_WEAK_PULL = 1'b1;
      end
      default: begin
      end
    endcase
    if (RST_PIN || RST) begin
      // Asynchronous: raw pin, no clock edge needed
      PORT_DRV.p1_o = PORT_RST;
      PORT_DRV.p2_o = PORT_RST;
      PORT_DRV.p3_o = PORT_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_ports_async: assert property (@(posedge MCLK) RST_PIN |-> PORT_DRV.p1_o == PORT_RST && PORT_DRV.p3_o == PORT_RST)
    else $error("ports not forced during reset");
  a_reset_len: assert property (@(posedge MCLK) disable iff (RST)
    (CE && rst_s && rcnt_ff == RCNT_W'(RESET_MIN_CYCLES - 1)) |=> st_ff == ST_RESET && pctrl_ff == PCTRL_RST)
    else $error("held reset not taken");
  a_idle_enter: assert property (@(posedge MCLK) disable iff (RST)
    (CE && st_ff == ST_RUN && INSTR_DONE && pctrl_ff[PCTRL_IDLE_BIT] && !pctrl_ff[PCTRL_PD_BIT] && !reset_hit)
    |=> st_ff == ST_IDLE)
    else $error("idle not entered");
  a_idle_halt: assert property (@(posedge MCLK) disable iff (RST)
    st_ff == ST_IDLE |-> CPU_HALT && !SPECIAL_FUNCTION_REGISTER_RESET)
    else $error("cpu not held in idle");
  a_idle_wake: assert property (@(posedge MCLK) disable iff (RST)
    (CE && st_ff == ST_IDLE && IRQ_PENDING && !reset_hit) |=> st_ff == ST_RUN)
    else $error("idle not left on interrupt");
  a_pd_osc: assert property (@(posedge MCLK) disable iff (RST)
    (CE && $rose(st_ff == ST_PDOWN)) |-> !osc_ff)
    else $error("oscillator runs in power-down");
  a_pd_strobes: assert property (@(posedge MCLK) disable iff (RST)
    st_ff == ST_PDOWN |-> !ALE_O && !PROGRAM_STORE_STROBE_O && (PORT_DRV.p0_oe == !EXT_PROG_MEM))
    else $error("power-down pin state wrong");
  a_idle_strobes: assert property (@(posedge MCLK) disable iff (RST)
    st_ff == ST_IDLE && EXT_PROG_MEM |-> ALE_O && PROGRAM_STORE_STROBE_O && PORT_DRV.p2_o == ADDR_HI)
    else $error("idle pin state wrong");
  a_emul_hold: assert property (@(posedge MCLK) disable iff (RST)
    (CE && st_ff == ST_EMUL && !reset_hit) |=> st_ff == ST_EMUL)
    else $error("emulation left without reset");
  a_emul_pins: assert property (@(posedge MCLK) disable iff (RST)
    st_ff == ST_EMUL |-> !PORT_DRV.p0_oe && PORT_DRV.weak_pull && OSC_RUN)
    else $error("emulation pin state wrong");
  a_pd_reset: assert property (@(posedge MCLK) disable iff (RST)
    (CE && st_ff == ST_PDOWN && reset_hit) |=> SPECIAL_FUNCTION_REGISTER_RESET && pctrl_ff == PCTRL_RST)
    else $error("reset exit incomplete");
  c_idle: cover property (@(posedge MCLK) disable iff (RST) st_ff == ST_IDLE ##1 st_ff == ST_RUN);
  c_pd_wake: cover property (@(posedge MCLK) disable iff (RST) st_ff == ST_PDOWN ##1 WAKE_IRQ);
  c_emul: cover property (@(posedge MCLK) disable iff (RST) st_ff == ST_EMUL);
endmodule // rstpwr_ctrl
`default_nettype wire

// *** dv/rstpwr_partner.sv ***
// Model of the external reset circuit, wake interrupt source and emulator strap
`timescale 1ns/100ps
`default_nettype none
module rstpwr_partner (
  input wire logic clk,
  output logic rst_pin,
  output logic irq0_n,
  output logic irq1_n,
  output logic ale_pin,
  output logic pstrobe_pin
);
  initial begin
    rst_pin = 1'b0;
    irq0_n = 1'b1;
    irq1_n = 1'b1;
    ale_pin = 1'b1;
    pstrobe_pin = 1'b1;
  end
  // Strap held low past release so the synchroniser sees it
  task automatic hold_reset(input int n, input logic emul);
    ale_pin <= ~emul;
    rst_pin <= 1'b1;
    repeat (n) @(posedge clk);
    rst_pin <= 1'b0;
    repeat (6) @(posedge clk);
    ale_pin <= 1'b1;
  endtask
  // Pin kept low well past the oscillator restart
  task automatic wake(input int n);
    irq0_n <= 1'b0;
    repeat (n) @(posedge clk);
    irq0_n <= 1'b1;
  endtask
endmodule // rstpwr_partner
`default_nettype wire

// *** dv/test_reset_and_low_power_control.sv ***
// Testbench for the reset, idle, power-down and emulation controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("FAIL t=%0t got %0h exp %0h", $time, g, e); end end
module test_reset_and_low_power_control;
  import rstpwr_pkg::*;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} row_t;
  logic MCLK, RST, INSTR_DONE, IRQ_PENDING, EXT_PROG_MEM, PSEL, PENABLE, PWRITE, cps, er, a;
  logic rst_pin, irq0_n, irq1_n, ale_pin, pstrobe_pin, OSC_DIV2, OSC_RUN, ALE_O, ALE_OE;
  logic PSO, STROBE_WEAK_PULL, CPU_HALT, WAKE_IRQ, PREADY, PSLVERR;
  logic ce, osc_in, osc_out, pso_oe, sfr_rst;
  logic [7:0] PADDR, p1, p2, ahi;
  logic [31:0] PWDATA, PRDATA, rd;
  portdrv_s PORT_DRV;
  int errors = 0;
  int checks_done = 0;
  row_t rows [11] = '{'{0, ADDR_PCTRL, 0, 0, 0}, '{0, ADDR_IRQCFG, 0, 0, 0},
    '{1, ADDR_PCTRL, 32'hc, 0, 0}, '{0, ADDR_PCTRL, 0, 32'hc, 0}, '{1, ADDR_IRQCFG, 32'hf, 0, 0},
    '{0, ADDR_IRQCFG, 0, 32'hf, 0}, '{1, 8'h10, 32'hffffffff, 0, 1}, '{0, 8'h10, 0, 0, 1},
    '{1, ADDR_PCTRL, 32'hfffffff0, 0, 0}, '{0, ADDR_PCTRL, 0, 0, 0}, '{1, ADDR_IRQCFG, 0, 0, 0}};
  always #5 MCLK = ~MCLK;
  rstpwr_ctrl #(.WAKE_CYCLES(100), .STARTUP_CYCLES(4)) rstpwr_ctrl_inst (.MCLK(MCLK), .RST(RST),
    .CE(ce), .RST_PIN(rst_pin), .OSC_INPUT_PIN(osc_in), .OSC_OUTPUT_PIN(osc_out), .OSC_DIV2(OSC_DIV2),
    .OSC_RUN(OSC_RUN), .EXT_IRQ_ZERO_N(irq0_n), .EXT_IRQ_ONE_N(irq1_n), .ALE_PIN_I(ale_pin),
    .PROGRAM_STORE_STROBE_I(pstrobe_pin), .ALE_O(ALE_O), .ALE_OE(ALE_OE), .PROGRAM_STORE_STROBE_O(PSO),
    .PROGRAM_STORE_STROBE_OE(pso_oe), .STROBE_WEAK_PULL(STROBE_WEAK_PULL), .EXT_PROG_MEM(EXT_PROG_MEM),
    .INSTR_DONE(INSTR_DONE), .IRQ_PENDING(IRQ_PENDING), .CPU_P0(8'h11), .CPU_P1(p1), .CPU_P2(p2),
    .CPU_P3(8'h44), .ADDR_HI(ahi), .CPU_ALE(1'b0), .CPU_PSTROBE(cps), .PORT_DRV(PORT_DRV),
    .CPU_HALT(CPU_HALT), .SPECIAL_FUNCTION_REGISTER_RESET(sfr_rst), .WAKE_IRQ(WAKE_IRQ),
    .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));
  rstpwr_partner rstpwr_partner_inst (.clk(MCLK), .rst_pin(rst_pin), .irq0_n(irq0_n), .irq1_n(irq1_n),
    .ale_pin(ale_pin), .pstrobe_pin(pstrobe_pin));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Answer taken at the edge where ready is seen, then one idle edge
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int i;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= ad;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge MCLK);
      if (PREADY === 1'b1) break;
    end
    er = PSLVERR;
    rd = PRDATA;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge MCLK);
    if (i == 20) begin
      errors++;
      end_sim;
    end
  endtask
  task automatic expect_status(input logic [31:0] x);
    int i;
    rd = 'x;
    for (i = 0; i < 40 && rd !== x; i++) apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rd, x)
    if (rd !== x) end_sim;
  endtask
  task automatic wait_for(input int s);
    int i;
    for (i = 0; i < 60; i++) begin
      @(negedge MCLK);
      if ((s == 0 && WAKE_IRQ === 1'b1) || (s == 1 && OSC_RUN === 1'b1)) break;
    end
    `CHK(i < 60, 1'b1)
    if (i == 60) end_sim;
    @(posedge MCLK);
  endtask
  task automatic finish_instr;
    INSTR_DONE <= 1'b1;
    @(posedge MCLK);
    INSTR_DONE <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {MCLK, INSTR_DONE, IRQ_PENDING, EXT_PROG_MEM, PSEL, PENABLE, PWRITE, cps} = '0;
    {PADDR, PWDATA, p1} = '0;
    {ce, osc_in} = 2'b10;
    RST = 1'b1;
    p2 = 8'h33;
    ahi = 8'h5a;
    repeat (8) @(posedge MCLK);
    RST <= 1'b0;
    @(negedge MCLK);
    `CHK({sfr_rst, CPU_HALT}, 2'b11)
    @(posedge MCLK);
    expect_status(32'h22);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      `CHK(er, rows[i].e)
      if (!rows[i].w) `CHK(rd, rows[i].x)
    end
    @(negedge MCLK);
    a = OSC_DIV2;
    `CHK(osc_out, 1'b1)
    @(negedge MCLK);
    `CHK(OSC_DIV2, ~a)
    @(posedge MCLK);
    ce <= 1'b0;
    osc_in <= 1'b1;
    @(negedge MCLK);
    a = OSC_DIV2;
    `CHK({osc_out, PREADY}, 2'b00)
    repeat (3) @(negedge MCLK);
    `CHK(OSC_DIV2, a)
    @(posedge MCLK);
    ce <= 1'b1;
    osc_in <= 1'b0;
    EXT_PROG_MEM <= 1'b1;
    apb(1'b1, ADDR_PCTRL, 32'h0d);
    `CHK(CPU_HALT, 1'b0)
    finish_instr;
    expect_status(32'h24);
    @(negedge MCLK);
    `CHK({ALE_O, ALE_OE, PSO}, 3'b111)
    `CHK({PORT_DRV.p0_oe, PORT_DRV.p2_o}, 9'h05a)
    @(posedge MCLK);
    IRQ_PENDING <= 1'b1;
    expect_status(32'h22);
    IRQ_PENDING <= 1'b0;
    apb(1'b0, ADDR_PCTRL, 32'h0);
    `CHK(rd, 32'h0c)
    apb(1'b1, ADDR_IRQCFG, 32'h5);
    apb(1'b1, ADDR_PCTRL, 32'h0e);
    finish_instr;
    @(negedge MCLK);
    `CHK({OSC_RUN, ALE_O, PSO, PORT_DRV.p0_oe, osc_out}, 5'h0)
    `CHK(PORT_DRV.p2_o, 8'h33)
    @(posedge MCLK);
    fork
      rstpwr_partner_inst.wake(30);
      begin
        wait_for(1);
        `CHK(CPU_HALT, 1'b1)
      end
    join
    wait_for(0);
    expect_status(32'h22);
    apb(1'b0, ADDR_PCTRL, 32'h0);
    `CHK(rd, 32'h0c)
    apb(1'b1, ADDR_PCTRL, 32'h0e);
    finish_instr;
    fork
      rstpwr_partner_inst.hold_reset(30, 1'b0);
      begin
        @(negedge MCLK);
        `CHK(PORT_DRV.p1_o, 8'hff)
        repeat (31) @(negedge MCLK);
        `CHK({sfr_rst, CPU_HALT}, 2'b11)
      end
    join
    expect_status(32'h22);
    apb(1'b0, ADDR_PCTRL, 32'h0);
    `CHK(rd, 32'h0)
    // Too short a pulse must leave the registers alone
    apb(1'b1, ADDR_PCTRL, 32'h0c);
    rstpwr_partner_inst.hold_reset(10, 1'b0);
    apb(1'b0, ADDR_PCTRL, 32'h0);
    `CHK(rd, 32'h0c)
    rstpwr_partner_inst.hold_reset(30, 1'b1);
    expect_status(32'h30);
    @(negedge MCLK);
    `CHK({STROBE_WEAK_PULL, PORT_DRV.p0_oe, OSC_RUN, ALE_OE, pso_oe, sfr_rst}, 6'b101000)
    @(posedge MCLK);
    rstpwr_partner_inst.hold_reset(30, 1'b0);
    expect_status(32'h22);
    end_sim;
  end
endmodule // test_reset_and_low_power_control
`default_nettype wire
